/* inc/sweep_switch_pkg.sv */
// shared constants, enumerations and register map of the horizontal sweep switcher
package sweep_switch_pkg;

  // clock and chop timing
  localparam int CLK_HZ         = 250_000_000;
  localparam int CHOP_FAST_HZ   = 2_000_000;
  localparam int CHOP_SLOW_HZ   = 200_000;
  localparam int CHOP_HALF_FAST = CLK_HZ / (2 * CHOP_FAST_HZ);
  localparam int CHOP_HALF_SLOW = CLK_HZ / (2 * CHOP_SLOW_HZ);
  localparam int CHOP_CNT_W     = 10;
  localparam logic [CHOP_CNT_W-1:0] CHOP_LAST_FAST = CHOP_CNT_W'(CHOP_HALF_FAST - 1);
  localparam logic [CHOP_CNT_W-1:0] CHOP_LAST_SLOW = CHOP_CNT_W'(CHOP_HALF_SLOW - 1);

  // modes
  typedef enum logic [1:0] {
    hmode_first     = 2'h0,
    hmode_second    = 2'h1,
    hmode_alternate = 2'h3,
    hmode_chopped   = 2'h2
  } horizontal_mode_e;

  typedef enum logic [2:0] {
    vmode_left      = 3'h0,
    vmode_right     = 3'h1,
    vmode_alternate = 3'h2,
    vmode_add       = 3'h3,
    vmode_chopped   = 3'h4
  } vertical_mode_e;

  typedef enum logic [1:0] {
    tsrc_follow = 2'h0,
    tsrc_left   = 2'h1,
    tsrc_right  = 2'h2
  } trigger_source_e;

  typedef enum logic [1:0] {
    seq_idle   = 2'h0,
    seq_enter  = 2'h1,
    seq_first  = 2'h3,
    seq_second = 2'h2
  } sequence_state_e;

  // register map (byte addresses)
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] REG_CONTROL   = 4'h0;
  localparam logic [ADDR_W-1:0] REG_INTENSITY = 4'h4;
  localparam logic [ADDR_W-1:0] REG_OFFSET    = 4'h8;
  localparam logic [ADDR_W-1:0] REG_STATUS    = 4'hc;

  // field layout
  localparam int CTL_MODE_LSB   = 0;
  localparam int CTL_SLOW_BIT   = 2;
  localparam int CTL_TSRC1_LSB  = 3;
  localparam int CTL_TSRC2_LSB  = 5;
  localparam int INT_W          = 8;
  localparam int INT_SECOND_LSB = 8;
  localparam int OFFSET_W       = 10;
  localparam logic [INT_W-1:0]    INTENSITY_RESET = 8'h80;
  localparam logic [OFFSET_W-1:0] OFFSET_RESET    = 10'h000;
  localparam int ST_SELECT_BIT  = 0;
  localparam int ST_PRES1_BIT   = 1;
  localparam int ST_PRES2_BIT   = 2;
  localparam int ST_BLOCK_BIT   = 3;
  localparam int ST_MODE_LSB    = 4;
  localparam int ST_SEQ_LSB     = 6;
  localparam int ST_CHOP_BIT    = 8;

endpackage

/* src/chop_divider.sv */
// divider that makes the equal-phase chop square wave from the system clock
`timescale 1ns/100ps
module chop_divider
  import sweep_switch_pkg::*;
(
  // clock and reset
  input  wire logic mclk_in,
  input  wire logic rst_in,
  // control
  input  wire logic run_in,
  input  wire logic slow_in,
  // chop outputs
  output logic      phase_out,
  output logic      toggle_out
);

  logic [CHOP_CNT_W-1:0] count;
  logic [CHOP_CNT_W-1:0] half_last;
  logic                  wrap;

  assign half_last = slow_in ? CHOP_LAST_SLOW : CHOP_LAST_FAST;
  // >= so that a rate change in mid phase cannot run the counter past the end
  assign wrap      = (count >= half_last);

  always_ff @(posedge mclk_in) begin
    if (rst_in || !run_in) begin
      count <= '0;
    end else if (wrap) begin
      count <= '0;
    end else begin
      count <= count + 1'b1;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in || !run_in) begin
      phase_out  <= 1'b0;
      toggle_out <= 1'b0;
    end else begin
      toggle_out <= wrap;
      if (wrap) begin
        phase_out <= ~phase_out;
      end
    end
  end

endmodule // chop_divider

/* src/trigger_router.sv */
// internal trigger source selection for one time-base unit
`timescale 1ns/100ps
module trigger_router
  import sweep_switch_pkg::*;
#(
  parameter int   TRIG_W       = 12,
  parameter logic PAIRED_RIGHT = 1'b1
)(
  // clock and reset
  input  wire logic                     mclk_in,
  input  wire logic                     rst_in,
  // selection
  input  wire trigger_source_e          source_in,
  input  wire vertical_mode_e           vertical_mode_in,
  input  wire logic                     vertical_right_shown_in,
  input  wire logic                     dual_sweep_in,
  // channel triggers
  input  wire logic signed [TRIG_W-1:0] left_trig_in,
  input  wire logic signed [TRIG_W-1:0] right_trig_in,
  // routed trigger
  output logic signed [TRIG_W:0]        trig_out
);

  function automatic logic signed [TRIG_W:0] widen(input logic signed [TRIG_W-1:0] v);
    widen = {v[TRIG_W-1], v};
  endfunction

  logic signed [TRIG_W:0] sum;
  logic                   follow_right;

  assign sum = widen(left_trig_in) + widen(right_trig_in);
  // independent pairs fix the channel per time base, else follow the display
  assign follow_right = dual_sweep_in ? PAIRED_RIGHT : vertical_right_shown_in;

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      trig_out <= '0;
    end else begin
      case (source_in)
        tsrc_left:  trig_out <= widen(left_trig_in);
        tsrc_right: trig_out <= widen(right_trig_in);
        default: begin
          case (vertical_mode_in)
            vmode_left:      trig_out <= widen(left_trig_in);
            vmode_right:     trig_out <= widen(right_trig_in);
            vmode_alternate: trig_out <= follow_right ? widen(right_trig_in)
                                                      : widen(left_trig_in);
            default:         trig_out <= sum;
          endcase
        end
      endcase
    end
  end

endmodule // trigger_router

/* src/horizontal_mode_sweep_switcher.sv */
// horizontal mode switcher: picks which time base drives the display
//
// What this block does
// - Single mode shows only the chosen time base; the other is ignored.
// - Alternate mode hands the display to the other unit after each sweep.
// - Alternate mode does not run if either time-base slot is empty.
// - In alternate the next unit is held off until the previous sweep ends.
// - Chopped mode switches between the two units at 2 MHz by default.
// - A rate select picks a chop rate of 200 kHz or 2 MHz.
// - Chopped mode gives both units equal time slots regardless of sweep rates.
// - In chopped mode an untriggered unit loses only its own trace.
// - Each trace gets its own intensity, chosen by the displayed unit.
// - Dual-sweep modes add an offset only while the second trace shows.
// - Each time base has its own trigger source: follow, left or right.
// - Follow selection tracks vertical mode and, in single modes, switches with vertical alternate.
// - Follow selection in sum or chopped vertical mode routes both triggers summed.
// - A chosen channel's trigger is routed even when that channel is not shown.
// - Vertical alternate with dual sweep pairs left with second, right with first.
`timescale 1ns/100ps
module horizontal_mode_sweep_switcher
  import sweep_switch_pkg::*;
#(
  parameter int TRIG_W = 12
)(
  // clock and reset
  input  wire logic                     mclk_in,
  input  wire logic                     rst_in,
  // avalon-mm slave
  input  wire logic [ADDR_W-1:0]        avs_address_in,
  input  wire logic                     avs_read_in,
  input  wire logic                     avs_write_in,
  input  wire logic [31:0]              avs_writedata_in,
  input  wire logic [3:0]               avs_byteenable_in,
  output logic [31:0]                   avs_readdata_out,
  output logic                          avs_waitrequest_out,
  // time-base slots (pins)
  input  wire logic                     first_gate_in,
  input  wire logic                     second_gate_in,
  input  wire logic                     first_present_in,
  input  wire logic                     second_present_in,
  // vertical mode logic (same clock)
  input  wire vertical_mode_e           vertical_mode_in,
  input  wire logic                     vertical_right_shown_in,
  input  wire logic signed [TRIG_W-1:0] left_trig_in,
  input  wire logic signed [TRIG_W-1:0] right_trig_in,
  // sweep arming to the time bases
  output logic                          first_arm_out,
  output logic                          second_arm_out,
  // display steering
  output logic                          display_second_out,
  output logic                          display_blank_out,
  output logic                          pair_right_out,
  output logic [INT_W-1:0]              intensity_out,
  output logic signed [OFFSET_W-1:0]    second_trace_offset_out,
  // routed internal triggers
  output logic signed [TRIG_W:0]        first_trig_out,
  output logic signed [TRIG_W:0]        second_trig_out
);

  generate
    if (TRIG_W < 2) begin : g_bad_width
      $error("trigger width must be at least 2");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: three flops, a change counts once flops two and three agree

  localparam int PIN_N = 4;
  logic [PIN_N-1:0] pin_raw;
  logic [PIN_N-1:0] pin_s1;
  logic [PIN_N-1:0] pin_s2;
  logic [PIN_N-1:0] pin_s3;
  logic [PIN_N-1:0] pin_level;

  assign pin_raw = {second_present_in, first_present_in, second_gate_in, first_gate_in};

  genvar gi;
  generate
    for (gi = 0; gi < PIN_N; gi++) begin : g_sync
      always_ff @(posedge mclk_in) begin
        if (rst_in) begin
          pin_s1[gi]    <= 1'b0;
          pin_s2[gi]    <= 1'b0;
          pin_s3[gi]    <= 1'b0;
          pin_level[gi] <= 1'b0;
        end else begin
          pin_s1[gi] <= pin_raw[gi];
          pin_s2[gi] <= pin_s1[gi];
          pin_s3[gi] <= pin_s2[gi];
          if (pin_s2[gi] == pin_s3[gi]) begin
            pin_level[gi] <= pin_s3[gi];
          end
        end
      end
    end
  endgenerate

  logic first_gate;
  logic second_gate;
  logic first_present;
  logic second_present;
  logic both_present;
  logic first_gate_d;
  logic second_gate_d;
  logic first_end;
  logic second_end;
  logic sweeps_idle;

  assign first_gate     = pin_level[0];
  assign second_gate    = pin_level[1];
  assign first_present  = pin_level[2];
  assign second_present = pin_level[3];
  assign both_present   = first_present && second_present;
  assign sweeps_idle    = !first_gate && !second_gate;

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      first_gate_d  <= 1'b0;
      second_gate_d <= 1'b0;
    end else begin
      first_gate_d  <= first_gate;
      second_gate_d <= second_gate;
    end
  end

  // end of sweep is the falling gate
  assign first_end  = first_gate_d && !first_gate;
  assign second_end = second_gate_d && !second_gate;

  ////////////////////////////////////////////////////////////////////////////
  // register bus: one wait state on every access

  horizontal_mode_e mode_req;
  logic             chop_slow;
  trigger_source_e  first_src;
  trigger_source_e  second_src;
  logic [INT_W-1:0] first_intensity;
  logic [INT_W-1:0] second_intensity;
  logic [OFFSET_W-1:0] offset_value;
  logic             bus_ack;
  logic             bus_req;
  logic             wr_take;

  assign bus_req             = avs_read_in || avs_write_in;
  assign avs_waitrequest_out = bus_req && !bus_ack;
  assign wr_take             = avs_write_in && bus_ack;

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      bus_ack <= 1'b0;
    end else begin
      bus_ack <= bus_req && !bus_ack;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      mode_req   <= hmode_first;
      chop_slow  <= 1'b0;
      first_src  <= tsrc_follow;
      second_src <= tsrc_follow;
    end else if (wr_take && avs_address_in == REG_CONTROL && avs_byteenable_in[0]) begin
      mode_req   <= horizontal_mode_e'(avs_writedata_in[CTL_MODE_LSB +: 2]);
      chop_slow  <= avs_writedata_in[CTL_SLOW_BIT];
      first_src  <= trigger_source_e'(avs_writedata_in[CTL_TSRC1_LSB +: 2]);
      second_src <= trigger_source_e'(avs_writedata_in[CTL_TSRC2_LSB +: 2]);
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      first_intensity  <= INTENSITY_RESET;
      second_intensity <= INTENSITY_RESET;
    end else if (wr_take && avs_address_in == REG_INTENSITY) begin
      if (avs_byteenable_in[0]) begin
        first_intensity <= avs_writedata_in[0 +: INT_W];
      end
      if (avs_byteenable_in[1]) begin
        second_intensity <= avs_writedata_in[INT_SECOND_LSB +: INT_W];
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      offset_value <= OFFSET_RESET;
    end else if (wr_take && avs_address_in == REG_OFFSET &&
                 avs_byteenable_in[0] && avs_byteenable_in[1]) begin
      offset_value <= avs_writedata_in[0 +: OFFSET_W];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mode taken over only between sweeps, so no trace is cut in half

  horizontal_mode_e active_mode;
  logic             dual_sweep;

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      active_mode <= hmode_first;
    end else if (sweeps_idle) begin
      active_mode <= mode_req;
    end
  end

  assign dual_sweep = (active_mode == hmode_alternate) || (active_mode == hmode_chopped);

  ////////////////////////////////////////////////////////////////////////////
  // alternate sequencer

  sequence_state_e seq_state;
  sequence_state_e next_seq_state;

  always_comb begin
    next_seq_state = seq_state;
    if (active_mode != hmode_alternate || !both_present) begin
      next_seq_state = seq_idle;
    end else begin
      case (seq_state)
        seq_idle:   next_seq_state = seq_enter;
        // a sweep left running from the old mode must end before the first arms
        seq_enter:  next_seq_state = sweeps_idle ? seq_first : seq_enter;
        seq_first:  next_seq_state = first_end ? seq_second : seq_first;
        seq_second: next_seq_state = second_end ? seq_first : seq_second;
        default:    next_seq_state = seq_idle;
      endcase
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      seq_state <= seq_idle;
    end else begin
      seq_state <= next_seq_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // chop rate

  logic chop_phase;

  chop_divider u_chop (
    .mclk_in    (mclk_in),
    .rst_in     (rst_in),
    .run_in     (active_mode == hmode_chopped),
    .slow_in    (chop_slow),
    .phase_out  (chop_phase),
    .toggle_out ()
  );

  ////////////////////////////////////////////////////////////////////////////
  // display source, arming and per-trace settings

  logic next_second;
  logic next_blank;
  logic next_first_arm;
  logic next_second_arm;

  always_comb begin
    next_second     = 1'b0;
    next_blank      = 1'b0;
    next_first_arm  = 1'b0;
    next_second_arm = 1'b0;
    case (active_mode)
      hmode_first: begin
        next_first_arm = 1'b1;
      end
      hmode_second: begin
        next_second     = 1'b1;
        next_second_arm = 1'b1;
      end
      hmode_alternate: begin
        // an unswept unit stalls both; free-running time bases avoid this
        next_second     = (seq_state == seq_second);
        next_blank      = (seq_state == seq_idle) || (seq_state == seq_enter);
        next_first_arm  = (seq_state == seq_first);
        next_second_arm = (seq_state == seq_second);
      end
      hmode_chopped: begin
        next_second     = chop_phase;
        next_first_arm  = 1'b1;
        next_second_arm = 1'b1;
      end
      default: begin
        next_blank = 1'b1;
      end
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      display_second_out <= 1'b0;
      display_blank_out  <= 1'b1;
      first_arm_out      <= 1'b0;
      second_arm_out     <= 1'b0;
    end else begin
      display_second_out <= next_second;
      display_blank_out  <= next_blank;
      first_arm_out      <= next_first_arm;
      second_arm_out     <= next_second_arm;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      intensity_out           <= INTENSITY_RESET;
      second_trace_offset_out <= OFFSET_RESET;
      pair_right_out          <= 1'b1;
    end else begin
      intensity_out <= next_second ? second_intensity : first_intensity;
      second_trace_offset_out <= (dual_sweep && next_second) ? offset_value
                                                             : OFFSET_RESET;
      pair_right_out <= !next_second;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // trigger routing; the first time base pairs with the right channel

  trigger_router #(
    .TRIG_W       (TRIG_W),
    .PAIRED_RIGHT (1'b1)
  ) u_first_trig (
    .mclk_in                 (mclk_in),
    .rst_in                  (rst_in),
    .source_in               (first_src),
    .vertical_mode_in        (vertical_mode_in),
    .vertical_right_shown_in (vertical_right_shown_in),
    .dual_sweep_in           (dual_sweep),
    .left_trig_in            (left_trig_in),
    .right_trig_in           (right_trig_in),
    .trig_out                (first_trig_out)
  );

  trigger_router #(
    .TRIG_W       (TRIG_W),
    .PAIRED_RIGHT (1'b0)
  ) u_second_trig (
    .mclk_in                 (mclk_in),
    .rst_in                  (rst_in),
    .source_in               (second_src),
    .vertical_mode_in        (vertical_mode_in),
    .vertical_right_shown_in (vertical_right_shown_in),
    .dual_sweep_in           (dual_sweep),
    .left_trig_in            (left_trig_in),
    .right_trig_in           (right_trig_in),
    .trig_out                (second_trig_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // read path

  logic [31:0] status_word;

  always_comb begin
    status_word                          = 32'h0000_0000;
    status_word[ST_SELECT_BIT]           = display_second_out;
    status_word[ST_PRES1_BIT]            = first_present;
    status_word[ST_PRES2_BIT]            = second_present;
    status_word[ST_BLOCK_BIT]            = (active_mode == hmode_alternate) && !both_present;
    status_word[ST_MODE_LSB +: 2]        = active_mode;
    status_word[ST_SEQ_LSB +: 2]         = seq_state;
    status_word[ST_CHOP_BIT]             = chop_phase;
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      avs_readdata_out <= 32'h0000_0000;
    end else if (avs_read_in && !bus_ack) begin
      case (avs_address_in)
        REG_CONTROL: begin
          avs_readdata_out <= 32'h0000_0000;
          avs_readdata_out[CTL_MODE_LSB +: 2]  <= mode_req;
          avs_readdata_out[CTL_SLOW_BIT]       <= chop_slow;
          avs_readdata_out[CTL_TSRC1_LSB +: 2] <= first_src;
          avs_readdata_out[CTL_TSRC2_LSB +: 2] <= second_src;
        end
        REG_INTENSITY: begin
          avs_readdata_out <= {16'h0000, second_intensity, first_intensity};
        end
        REG_OFFSET: begin
          avs_readdata_out <= {22'h000000, offset_value};
        end
        REG_STATUS: begin
          avs_readdata_out <= status_word;
        end
        default: begin
          avs_readdata_out <= 32'h0000_0000;
        end
      endcase
    end
  end

endmodule // horizontal_mode_sweep_switcher

/* tb/horizontal_mode_sweep_switcher_sva.sv */
// checker: steering and timing properties at the sweep switcher ports
`timescale 1ns/100ps
module sweep_switcher_checker
  import sweep_switch_pkg::*;
(
  input wire logic                  mclk_in,
  input wire logic                  rst_in,
  input wire logic [ADDR_W-1:0]     avs_address_in,
  input wire logic                  avs_read_in,
  input wire logic                  avs_write_in,
  input wire logic [31:0]           avs_readdata_out,
  input wire logic                  avs_waitrequest_out,
  input wire logic                  first_gate_in,
  input wire logic                  second_gate_in,
  input wire logic                  first_arm_out,
  input wire logic                  second_arm_out,
  input wire logic                  display_second_out,
  input wire logic                  display_blank_out,
  input wire logic                  pair_right_out,
  input wire logic signed [OFFSET_W-1:0] second_trace_offset_out
);
  logic       prev_ds;
  logic       slot_ok;
  logic [9:0] run;
  wire        chg  = display_second_out != prev_ds;
  wire        both = first_arm_out && second_arm_out;
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  // a slot only counts when both switches that bound it happened while chopping
  always_ff @(posedge mclk_in) begin
    prev_ds <= display_second_out;
    run     <= chg ? 10'h000 : run + 10'h001;
    slot_ok <= chg ? both : slot_ok && both;
  end
  a_reset_state: assert property (disable iff (1'b0) rst_in |=> display_blank_out
    && !first_arm_out && !second_arm_out && pair_right_out) else $error("bad reset state");
  a_pair_inverse: assert property (pair_right_out == !display_second_out)
    else $error("pairing not inverse of display");
  a_one_wait: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
    |=> !avs_waitrequest_out) else $error("more than one wait state");
  a_unmapped_zero: assert property (avs_read_in && !avs_waitrequest_out
    && avs_address_in[1:0] != 2'h0 |-> avs_readdata_out == 32'h0) else $error("unmapped read");
  a_blank_disarm: assert property (display_blank_out |-> !first_arm_out && !second_arm_out)
    else $error("armed while blanked");
  a_chop_slot: assert property (chg && slot_ok && both |-> run == CHOP_LAST_FAST
    || run == CHOP_LAST_SLOW) else $error("chop slot length wrong");
  a_offset_second: assert property (|second_trace_offset_out |-> display_second_out)
    else $error("offset while first shown");
  a_hold_second: assert property ($rose(second_arm_out) && !first_arm_out |-> !first_gate_in)
    else $error("second armed during first sweep");
  a_hold_first: assert property ($rose(first_arm_out) && !second_arm_out |-> !second_gate_in)
    else $error("first armed during second sweep");
  c_handover: cover property ($rose(second_arm_out) && !first_arm_out);
  c_chop_slot: cover property (chg && slot_ok && both);
  c_blank: cover property ($rose(display_blank_out));
endmodule // sweep_switcher_checker

bind horizontal_mode_sweep_switcher sweep_switcher_checker u_chk (.*);

/* tb/timebase_model.sv */
// time-base plug-in model: sweeps whenever armed unless held untriggered
`timescale 1ns/100ps
module timebase_model #(
  parameter int SWEEP = 20,
  parameter int GAP   = 10
)(
  input  wire logic mclk_in,
  input  wire logic arm_in,
  input  wire logic stall_in,
  output logic      gate_out
);
  int n = 0;
  initial gate_out = 1'b0;
  // free-runs when armed and stall_in is low, so an alternate sequence waits on a trigger only while stall_in is held
  always @(posedge mclk_in) begin
    if (n > 0)
      n <= n - 1;
    else if (gate_out) begin
      gate_out <= 1'b0;
      n        <= GAP;
    end else if (arm_in && !stall_in) begin
      gate_out <= 1'b1;
      n        <= SWEEP;
    end
  end
endmodule // timebase_model

/* tb/test_horizontal_mode_sweep_switcher.sv */
// testbench for the horizontal sweep switcher
`timescale 1ns/100ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin n_errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module test_horizontal_mode_sweep_switcher;
  import sweep_switch_pkg::*;
  typedef struct packed {
    logic [7:0] ctl; logic [2:0] vm; logic sh; logic [12:0] e1; logic [12:0] e2;
  } row_s;
  logic mclk_in = 0, rst_in = 1, rd = 0, wr = 0, p1 = 1, p2 = 1, st2 = 0, sh = 0;
  logic [3:0]  adr = 4'h0, be = 4'hf;
  logic signed [11:0] lt = 12'sh005, rt = -12'sh003;
  logic [31:0] wd = 32'h0, q, rdat;
  logic wrq, g1, g2, a1, a2, ds, bl, pr;
  logic [7:0]  inten;
  logic [9:0]  ofs;
  logic [12:0] t1, t2;
  vertical_mode_e vm = vmode_left;
  int n_errors = 0, compares = 0, n;
  row_s rows[7] = '{'{8'h00, 3'h0, 1'b0, 13'h0005, 13'h0005},
    '{8'h00, 3'h1, 1'b0, 13'h1ffd, 13'h1ffd}, '{8'h00, 3'h3, 1'b0, 13'h0002, 13'h0002},
    '{8'h00, 3'h4, 1'b0, 13'h0002, 13'h0002}, '{8'h00, 3'h2, 1'b1, 13'h1ffd, 13'h1ffd},
    '{8'h48, 3'h1, 1'b0, 13'h0005, 13'h1ffd}, '{8'h02, 3'h2, 1'b0, 13'h1ffd, 13'h0005}};
  horizontal_mode_sweep_switcher DUT (.mclk_in(mclk_in), .rst_in(rst_in),
    .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
    .avs_byteenable_in(be), .avs_readdata_out(rdat), .avs_waitrequest_out(wrq),
    .first_gate_in(g1), .second_gate_in(g2), .first_present_in(p1),
    .second_present_in(p2), .vertical_mode_in(vm), .vertical_right_shown_in(sh),
    .left_trig_in(lt), .right_trig_in(rt), .first_arm_out(a1),
    .second_arm_out(a2), .display_second_out(ds), .display_blank_out(bl),
    .pair_right_out(pr), .intensity_out(inten), .second_trace_offset_out(ofs),
    .first_trig_out(t1), .second_trig_out(t2));
  timebase_model #(.SWEEP(20), .GAP(10)) u_first (.mclk_in(mclk_in), .arm_in(a1),
    .stall_in(1'b0), .gate_out(g1));
  timebase_model #(.SWEEP(45), .GAP(12)) u_second (.mclk_in(mclk_in), .arm_in(a2),
    .stall_in(st2), .gate_out(g2));
  //////////////////////////////////////////////////////////////
  task automatic results;
    $display("compares=%0d n_errors=%0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int i;
    i = 0;
    @(posedge mclk_in);
    rd <= !w; wr <= w; adr <= a; wd <= d;
    do begin @(posedge mclk_in); i++; end while (wrq !== 1'b0 && i < 50);
    if (i >= 50) begin n_errors++; results(); end
    q = rdat;
    rd <= 1'b0; wr <= 1'b0;
  endtask
  task automatic wait_ds(input logic v);
    int i;
    i = 0;
    while (ds !== v && i < 3000) begin @(posedge mclk_in); i++; end
    if (i >= 3000) begin n_errors++; results(); end
  endtask
  // measures one whole chop slot, starting at a switch so a partial slot is never counted
  task automatic slot;
    logic v;
    v = ds;
    wait_ds(!v);
    v = ds;
    n = 0;
    while (ds === v && n < 2000) begin @(posedge mclk_in); n++; end
  endtask
  //////////////////////////////////////////////////////////////
  initial begin forever #2 mclk_in = ~mclk_in; end
  initial begin
    repeat (2) @(posedge mclk_in);
    rst_in <= 1'b0;
    foreach (rows[i]) begin
      bus(1'b1, REG_CONTROL, {24'h0, rows[i].ctl});
      vm <= vertical_mode_e'(rows[i].vm);
      sh <= rows[i].sh;
      repeat (60) @(posedge mclk_in);
      `CHK(t1, rows[i].e1)
      `CHK(t2, rows[i].e2)
      $display("trigger row %0d done", i);
    end
    // second held idle so the switch into alternate finds both sweeps ended
    st2 <= 1'b1;
    bus(1'b1, REG_INTENSITY, 32'h3311);
    bus(1'b1, REG_OFFSET, 32'h07f);
    bus(1'b1, REG_CONTROL, 32'h3);
    repeat (150) @(posedge mclk_in);
    st2 <= 1'b0;
    wait_ds(1'b1); repeat (2) @(posedge mclk_in);
    `CHK(inten, 8'h33)
    `CHK(ofs, 10'h07f)
    `CHK(a1, 1'b0)
    wait_ds(1'b0); repeat (2) @(posedge mclk_in);
    `CHK(inten, 8'h11)
    `CHK(ofs, 10'h000)
    st2 <= 1'b1;
    wait_ds(1'b1); repeat (200) @(posedge mclk_in);
    `CHK(ds, 1'b1)
    `CHK(a1, 1'b0)
    st2 <= 1'b0;
    wait_ds(1'b0);
    p2 <= 1'b0; repeat (20) @(posedge mclk_in);
    `CHK({bl, a1, a2}, 3'h4)
    bus(1'b0, REG_STATUS, 32'h0);
    `CHK(q[ST_PRES2_BIT], 1'b0)
    `CHK(q[ST_BLOCK_BIT], 1'b1)
    p2 <= 1'b1; repeat (60) @(posedge mclk_in);
    `CHK(bl, 1'b0)
    $display("alternate test done");
    st2 <= 1'b1;
    bus(1'b1, REG_CONTROL, 32'h2); repeat (60) @(posedge mclk_in);
    slot; `CHK(n, CHOP_HALF_FAST)
    bus(1'b1, REG_CONTROL, 32'h0); repeat (60) @(posedge mclk_in);
    bus(1'b1, REG_CONTROL, 32'h6); repeat (60) @(posedge mclk_in);
    slot; `CHK(n, CHOP_HALF_SLOW)
    // second stays stalled so the reset below cannot cut one of its sweeps
    bus(1'b1, REG_CONTROL, 32'h1); repeat (80) @(posedge mclk_in);
    `CHK({ds, a1, a2}, 3'h5)
    $display("chop and single test done");
    bus(1'b1, 4'h2, 32'h3);
    bus(1'b0, REG_CONTROL, 32'h0);
    `CHK(q, 32'h1)
    bus(1'b0, 4'h2, 32'h0);
    `CHK(q, 32'h0)
    rst_in <= 1'b1; repeat (2) @(posedge mclk_in);
    rst_in <= 1'b0; @(posedge mclk_in);
    `CHK({bl, pr, inten}, 10'h380)
    bus(1'b0, REG_INTENSITY, 32'h0);
    `CHK(q, 32'h8080)
    be <= 4'h1;
    bus(1'b1, REG_INTENSITY, 32'h5555);
    bus(1'b0, REG_INTENSITY, 32'h0);
    `CHK(q, 32'h8055)
    $display("reset test done");
    results();
  end
endmodule // test_horizontal_mode_sweep_switcher
